// ### design/pin_sync2.sv
// two-flop synchroniser for asynchronous pin levels
module pin_sync2 #(
  parameter int WIDTH = 8
) (
  input  logic             i_clk_sys,
  input  logic             i_rst,
  input  logic [WIDTH-1:0] i_async,
  output logic [WIDTH-1:0] o_sync
);

  logic [WIDTH-1:0] meta_ff;
  logic [WIDTH-1:0] sync_ff;

  // the first stage feeds the second stage only
  always_ff @(posedge i_clk_sys or posedge i_rst)
  begin
    if (i_rst)
    begin
      meta_ff <= '0;
      sync_ff <= '0;
    end
    else
    begin
      meta_ff <= i_async;
      sync_ff <= meta_ff;
    end
  end

  assign o_sync = sync_ff;

endmodule : pin_sync2

// ### design/tdm_alarm_pkg.sv
// constants, field layout and carrier types for the per-port tdm alarm registers
package tdm_alarm_pkg;

  localparam int PORT_COUNT = 8;
  localparam int CHAN_W     = 5;
  localparam int ADDR_W     = 16;
  localparam int DATA_W     = 16;
  localparam int MAP_W      = 32;
  localparam int PORT_W     = 3;

  // register map: port p sits at base + p * stride
  localparam logic [15:0] CTRL1_BASE_ADDR    = 16'h6200;
  localparam logic [15:0] ALARM_BASE_ADDR    = 16'h6206;
  localparam logic [15:0] MAP_HIGH_BASE_ADDR = 16'h6208;
  localparam logic [15:0] MAP_LOW_BASE_ADDR  = 16'h620a;
  localparam logic [15:0] PORT_STRIDE        = 16'h0010;

  // address split: page above the port field, port number, slot within the port
  localparam int PAGE_LSB = 7;
  localparam int PORT_LSB = 4;
  localparam int SLOT_W   = 4;
  localparam logic [8:0] BLOCK_PAGE = CTRL1_BASE_ADDR[15:PAGE_LSB];
  localparam logic [3:0] SLOT_CTRL1 = CTRL1_BASE_ADDR[3:0];
  localparam logic [3:0] SLOT_ALARM = ALARM_BASE_ADDR[3:0];
  localparam logic [3:0] SLOT_HIGH  = MAP_HIGH_BASE_ADDR[3:0];
  localparam logic [3:0] SLOT_LOW   = MAP_LOW_BASE_ADDR[3:0];

  // alarm register fields
  localparam int RSVD_BIT    = 0;
  localparam int ALERT_LSB   = 1;
  localparam int ALERT_MSB   = 5;
  localparam int STATUS_LSB  = 6;
  localparam int STATUS_MSB  = 10;
  localparam int REPORT_LSB  = 11;
  localparam int REPORT_MSB  = 15;

  // index of each condition inside the five-bit enable and status vectors
  localparam int ST_LOS    = 0;
  localparam int ST_UDT    = 1;
  localparam int ST_SDT    = 2;
  localparam int ST_PERM   = 3;
  localparam int ST_SIMPLE = 4;

  localparam logic [15:0] ALARM_RESET = 16'h0040;
  localparam logic [15:0] MAP_RESET   = 16'h0000;

  // data mode field of control register 1
  localparam int MODE_LSB = 13;
  localparam int MODE_MSB = 14;
  localparam logic [1:0] MODE_NONE         = 2'h0;
  localparam logic [1:0] MODE_UNSTRUCTURED = 2'h1;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic              rd;
    logic              wr;
    logic [DATA_W-1:0] wdata;
  } reg_req_type;

  typedef struct packed {
    logic              hit;
    logic              ctrl1;
    logic [PORT_W-1:0] port;
    logic [SLOT_W-1:0] slot;
  } reg_decode_type;

  typedef struct packed {
    logic              udt_outbuf_error;
    logic              sdt_outbuf_error;
    logic              perm_underrun;
    logic              perm_enable;
    logic [CHAN_W-1:0] perm_channel;
    logic              simple_underrun;
    logic              simple_enable;
    logic [CHAN_W-1:0] simple_channel;
  } port_event_type;

endpackage : tdm_alarm_pkg

// ### design/tdm_port_alarm_status_regs.sv
// per-port tdm alarm, underrun report and service flag registers
// Notes on behaviour
// - loss-of-signal enabled and latched raises service
// - unstructured buffer error enabled raises service
// - structured buffer error enabled raises service
// - permanent underrun enabled raises service
// - simple underrun enabled raises service
// - loss-of-signal pin latches bit 6, zero clears
// - loss clear ignored until control 1 written
// - unstructured buffer error latches bit 7
// - structured buffer error latches bit 8
// - enabled permanent underrun latches bit 9
// - enabled simple underrun latches bit 10
// - bits 15:11 hold last simple underrun channel
// - map high half in fifth register
// - map low half in sixth register
// - permanent underrun sets channel bit, zero write clears
// - port p registers at base plus p*10h
// - data mode selects which status bits apply
module tdm_port_alarm_status_regs
  import tdm_alarm_pkg::*;
(
  input  logic                  i_clk_sys,
  input  logic                  i_rst,
  input  reg_req_type           i_reg_req,
  input  logic [PORT_COUNT-1:0] i_loss_of_signal_input_pin,
  input  port_event_type        i_port_event [PORT_COUNT],
  output logic                  o_reg_ack,
  output logic [DATA_W-1:0]     o_reg_rdata,
  output logic                  o_tdm_service_request,
  output logic [PORT_COUNT-1:0] o_port_service
);

  // splits a host address into port and slot; used for both reads and writes
  function automatic reg_decode_type decode_addr(input logic [ADDR_W-1:0] addr);
    reg_decode_type d;
    logic           page_ok;
    page_ok = (addr[ADDR_W-1:PAGE_LSB] == BLOCK_PAGE);
    d.port  = addr[PAGE_LSB-1:PORT_LSB];
    d.slot  = addr[SLOT_W-1:0];
    d.ctrl1 = page_ok && (d.slot == SLOT_CTRL1);
    d.hit   = page_ok && ((d.slot == SLOT_ALARM) || (d.slot == SLOT_HIGH) || (d.slot == SLOT_LOW));
    return d;
  endfunction : decode_addr

  // mode decode shared by every port; 00 latches nothing at all
  function automatic logic mode_is_unstructured(input logic [1:0] mode);
    logic res;
    case (mode)
      MODE_UNSTRUCTURED:
      begin
        res = 1'b1;
      end
      default:
      begin
        res = 1'b0;
      end
    endcase
    return res;
  endfunction : mode_is_unstructured

  // both remaining codes select structured transport, the large-channel variant included
  function automatic logic mode_is_structured(input logic [1:0] mode);
    logic res;
    case (mode)
      MODE_NONE:
      begin
        res = 1'b0;
      end
      MODE_UNSTRUCTURED:
      begin
        res = 1'b0;
      end
      default:
      begin
        res = 1'b1;
      end
    endcase
    return res;
  endfunction : mode_is_structured

  reg_decode_type dec;

  logic [PORT_COUNT-1:0] los_sync;

  logic [PORT_COUNT-1:0] programmed_ff;
  logic [1:0]            mode_ff       [PORT_COUNT];
  logic [4:0]            alert_en_ff   [PORT_COUNT];
  logic [4:0]            status_ff     [PORT_COUNT];
  logic [4:0]            nxt_status    [PORT_COUNT];
  logic [CHAN_W-1:0]     report_ff     [PORT_COUNT];
  logic [MAP_W-1:0]      map_ff        [PORT_COUNT];
  logic [MAP_W-1:0]      nxt_map       [PORT_COUNT];
  logic [DATA_W-1:0]     alarm_word    [PORT_COUNT];
  logic [PORT_COUNT-1:0] port_cond;

  logic                  ack_ff;
  logic [DATA_W-1:0]     rdata_ff;
  logic [DATA_W-1:0]     nxt_rdata;
  logic                  service_ff;
  logic [PORT_COUNT-1:0] port_service_ff;

  assign dec = decode_addr(i_reg_req.addr);

  // the loss-of-signal pin is asynchronous to the system clock
  pin_sync2 #(
    .WIDTH (PORT_COUNT)
  ) u_los_sync (
    .i_clk_sys (i_clk_sys),
    .i_rst     (i_rst),
    .i_async   (i_loss_of_signal_input_pin),
    .o_sync    (los_sync)
  );

  genvar p;
  generate
    for (p = 0; p < PORT_COUNT; p++)
    begin : g_port
      logic             sel;
      logic             wr_ctrl1;
      logic             wr_alarm;
      logic             wr_high;
      logic             wr_low;
      logic             unstructured;
      logic             structured;
      logic [4:0]       set_vec;
      logic [4:0]       clr_vec;
      logic [MAP_W-1:0] set_map;
      logic [MAP_W-1:0] clr_map;

      assign sel      = i_reg_req.wr && (dec.port == PORT_W'(p));
      assign wr_ctrl1 = sel && dec.ctrl1;
      assign wr_alarm = sel && dec.hit && (dec.slot == SLOT_ALARM);
      assign wr_high  = sel && dec.hit && (dec.slot == SLOT_HIGH);
      assign wr_low   = sel && dec.hit && (dec.slot == SLOT_LOW);

      assign unstructured = mode_is_unstructured(mode_ff[p]);
      assign structured   = mode_is_structured(mode_ff[p]);

      // control register 1 lives elsewhere; its writes are watched for arming and mode
      always_ff @(posedge i_clk_sys or posedge i_rst)
      begin
        if (i_rst)
        begin
          programmed_ff[p] <= 1'b0;
        end
        else if (wr_ctrl1)
        begin
          programmed_ff[p] <= 1'b1;
        end
      end

      always_ff @(posedge i_clk_sys or posedge i_rst)
      begin
        if (i_rst)
        begin
          mode_ff[p] <= MODE_NONE;
        end
        else if (wr_ctrl1)
        begin
          mode_ff[p] <= i_reg_req.wdata[MODE_MSB:MODE_LSB];
        end
      end

      always_ff @(posedge i_clk_sys or posedge i_rst)
      begin
        if (i_rst)
        begin
          alert_en_ff[p] <= ALARM_RESET[ALERT_MSB:ALERT_LSB];
        end
        else if (wr_alarm)
        begin
          alert_en_ff[p] <= i_reg_req.wdata[ALERT_MSB:ALERT_LSB];
        end
      end

      always_comb
      begin
        set_vec            = '0;
        set_vec[ST_LOS]    = los_sync[p] && unstructured;
        set_vec[ST_UDT]    = i_port_event[p].udt_outbuf_error && unstructured;
        set_vec[ST_SDT]    = i_port_event[p].sdt_outbuf_error && structured;
        set_vec[ST_PERM]   = i_port_event[p].perm_underrun && i_port_event[p].perm_enable
                             && structured;
        set_vec[ST_SIMPLE] = i_port_event[p].simple_underrun && i_port_event[p].simple_enable
                             && structured;
      end

      always_comb
      begin
        clr_vec = '0;
        if (wr_alarm)
        begin
          clr_vec = ~i_reg_req.wdata[STATUS_MSB:STATUS_LSB];
          // a loss-of-signal clear that arrives before control register 1 is written is dropped
          clr_vec[ST_LOS] = clr_vec[ST_LOS] && programmed_ff[p];
        end
      end

      // a new event in the clearing cycle survives the clear
      assign nxt_status[p] = set_vec | (status_ff[p] & ~clr_vec);

      always_ff @(posedge i_clk_sys or posedge i_rst)
      begin
        if (i_rst)
        begin
          status_ff[p] <= ALARM_RESET[STATUS_MSB:STATUS_LSB];
        end
        else
        begin
          status_ff[p] <= nxt_status[p];
        end
      end

      always_ff @(posedge i_clk_sys or posedge i_rst)
      begin
        if (i_rst)
        begin
          report_ff[p] <= ALARM_RESET[REPORT_MSB:REPORT_LSB];
        end
        else if (i_port_event[p].simple_underrun && structured)
        begin
          report_ff[p] <= i_port_event[p].simple_channel;
        end
      end

      always_comb
      begin
        set_map = '0;
        if (i_port_event[p].perm_underrun && structured)
        begin
          set_map = MAP_W'(1) << i_port_event[p].perm_channel;
        end
      end

      always_comb
      begin
        clr_map = '0;
        if (wr_high)
        begin
          clr_map[MAP_W-1:DATA_W] = ~i_reg_req.wdata;
        end
        if (wr_low)
        begin
          clr_map[DATA_W-1:0] = ~i_reg_req.wdata;
        end
      end

      assign nxt_map[p] = set_map | (map_ff[p] & ~clr_map);

      always_ff @(posedge i_clk_sys or posedge i_rst)
      begin
        if (i_rst)
        begin
          map_ff[p] <= {MAP_RESET, MAP_RESET};
        end
        else
        begin
          map_ff[p] <= nxt_map[p];
        end
      end

      always_comb
      begin
        alarm_word[p]                        = '0;
        alarm_word[p][ALERT_MSB:ALERT_LSB]   = alert_en_ff[p];
        alarm_word[p][STATUS_MSB:STATUS_LSB] = status_ff[p];
        alarm_word[p][REPORT_MSB:REPORT_LSB] = report_ff[p];
      end

      // enable bit i guards status bit i, so one AND covers all five conditions
      assign port_cond[p] = |(alert_en_ff[p] & status_ff[p]);
    end
  endgenerate

  always_comb
  begin
    nxt_rdata = '0;
    if (i_reg_req.rd && dec.hit)
    begin
      case (dec.slot)
        SLOT_ALARM:
        begin
          nxt_rdata = alarm_word[dec.port];
        end
        SLOT_HIGH:
        begin
          nxt_rdata = map_ff[dec.port][MAP_W-1:DATA_W];
        end
        SLOT_LOW:
        begin
          nxt_rdata = map_ff[dec.port][DATA_W-1:0];
        end
        default:
        begin
          nxt_rdata = '0;
        end
      endcase
    end
  end

  // unmapped addresses give no ack so that another register block may answer
  always_ff @(posedge i_clk_sys or posedge i_rst)
  begin
    if (i_rst)
    begin
      ack_ff <= 1'b0;
    end
    else
    begin
      ack_ff <= (i_reg_req.rd || i_reg_req.wr) && dec.hit;
    end
  end

  // read data falls back to zero after its cycle so it can be ored with other blocks
  always_ff @(posedge i_clk_sys or posedge i_rst)
  begin
    if (i_rst)
    begin
      rdata_ff <= '0;
    end
    else
    begin
      rdata_ff <= nxt_rdata;
    end
  end

  // registered flag trails its cause by one cycle, kept glitch free for the main status
  always_ff @(posedge i_clk_sys or posedge i_rst)
  begin
    if (i_rst)
    begin
      service_ff <= 1'b0;
    end
    else
    begin
      service_ff <= |port_cond;
    end
  end

  always_ff @(posedge i_clk_sys or posedge i_rst)
  begin
    if (i_rst)
    begin
      port_service_ff <= '0;
    end
    else
    begin
      port_service_ff <= port_cond;
    end
  end

  assign o_reg_ack             = ack_ff;
  assign o_reg_rdata           = rdata_ff;
  assign o_tdm_service_request = service_ff;
  assign o_port_service        = port_service_ff;

endmodule : tdm_port_alarm_status_regs

// ### verification/host_port_model.sv
// host side of the register port: one strobed access per call
module host_port_model
  import tdm_alarm_pkg::*;
(
  input  wire logic        i_clk_sys,
  input  wire logic        i_ack,
  input  wire logic [15:0] i_rdata,
  output reg_req_type      o_req
);
  timeunit 1ns;
  timeprecision 1ps;
  initial o_req = '0;
  // strobe is up for one taking edge only, a held strobe would be a second request
  task automatic access(input logic w, input logic [15:0] a, input logic [15:0] wd,
                        output logic ack, output logic [15:0] rd);
    @(posedge i_clk_sys);
    o_req <= '{addr: a, rd: !w, wr: w, wdata: wd};
    @(posedge i_clk_sys);
    o_req <= '{addr: ~a, rd: 1'b0, wr: 1'b0, wdata: ~wd};
    #1;
    ack = i_ack;
    rd = i_rdata;
  endtask : access
endmodule : host_port_model

// ### verification/tdm_alarm_checker.sv
// concurrent checks on the alarm register port and the service outputs
module tdm_alarm_checker
  import tdm_alarm_pkg::*;
(
  input wire logic                  i_clk_sys,
  input wire logic                  i_rst,
  input wire reg_req_type           i_reg_req,
  input wire logic                  o_reg_ack,
  input wire logic [DATA_W-1:0]     o_reg_rdata,
  input wire logic                  o_tdm_service_request,
  input wire logic [PORT_COUNT-1:0] o_port_service
);
  timeunit 1ns;
  timeprecision 1ps;
  logic req;
  logic hit;
  assign req = i_reg_req.rd | i_reg_req.wr;
  assign hit = i_reg_req.addr[15:7] == BLOCK_PAGE &&
               i_reg_req.addr[3:0] inside {SLOT_ALARM, SLOT_HIGH, SLOT_LOW};
  default clocking cb @(posedge i_clk_sys);
  endclocking
  default disable iff (i_rst);
  sequence s_alarm_read;
    i_reg_req.rd && hit && i_reg_req.addr[3:0] == SLOT_ALARM ##1 o_reg_ack;
  endsequence
  AST_ACK_HIT: assert property (req && hit |=> o_reg_ack)
    else $error("hit not acknowledged");
  AST_MISS_SILENT: assert property (req && !hit |=> !o_reg_ack && o_reg_rdata == '0)
    else $error("miss answered");
  AST_IDLE_NO_ACK: assert property (!req |=> !o_reg_ack)
    else $error("ack without request");
  AST_ACK_CAUSE: assert property ($rose(o_reg_ack) |-> $past(req))
    else $error("ack rose without request");
  AST_RDATA_IDLE: assert property (!i_reg_req.rd |=> o_reg_rdata == '0)
    else $error("read data outside read");
  AST_BIT0_ZERO: assert property (s_alarm_read |-> !o_reg_rdata[RSVD_BIT])
    else $error("reserved bit set");
  AST_PORT_SRV: assert property (s_alarm_read |->
    o_port_service[$past(i_reg_req.addr[6:4])] == |(o_reg_rdata[5:1] & o_reg_rdata[10:6]))
    else $error("port service differs from word");
  AST_SRV_OR: assert property (o_tdm_service_request == |o_port_service)
    else $error("service is not the port or");
endmodule : tdm_alarm_checker

bind tdm_port_alarm_status_regs tdm_alarm_checker u_chk (
  .i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_reg_req(i_reg_req), .o_reg_ack(o_reg_ack),
  .o_reg_rdata(o_reg_rdata), .o_tdm_service_request(o_tdm_service_request), .o_port_service(o_port_service)
);

// ### verification/tdm_port_alarm_status_regs_tb.sv
// self-checking bench for the tdm alarm registers against a reference model
`define CHK(n, e, g) begin checks_done++; if ((g) !== (e)) begin bad_count++; \
  $display("wrong value %s exp %0h got %0h", n, e, g); end end
module tdm_port_alarm_status_regs_tb
  import tdm_alarm_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic                  i_clk_sys = 1'b0;
  logic                  i_rst = 1'b1;
  logic [PORT_COUNT-1:0] los = '0;
  port_event_type        ev [PORT_COUNT];
  reg_req_type           req;
  logic                  ack;
  logic                  srv;
  logic [15:0]           rdata;
  logic [PORT_COUNT-1:0] psrv;
  logic [15:0]           m_alarm [PORT_COUNT];
  logic [31:0]           m_map [PORT_COUNT];
  logic [1:0]            m_mode [PORT_COUNT];
  logic [PORT_COUNT-1:0] m_prog = '0;
  logic [31:0]           seed = 32'h00764f20;
  logic [31:0]           r;
  int                    q;
  int                    bad_count = 0;
  int                    checks_done = 0;
  int                    cycles = 0;
  tdm_port_alarm_status_regs DUT (.i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_reg_req(req),
    .i_loss_of_signal_input_pin(los), .i_port_event(ev), .o_reg_ack(ack), .o_reg_rdata(rdata),
    .o_tdm_service_request(srv), .o_port_service(psrv));
  host_port_model host (.i_clk_sys(i_clk_sys), .i_ack(ack), .i_rdata(rdata), .o_req(req));
  always #4 i_clk_sys = ~i_clk_sys;
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd
  task automatic rw(input logic w, input int p, input logic [3:0] s, input logic [15:0] wd);
    logic        a;
    logic [15:0] d;
    logic [15:0] e;
    // the pin is a level: a latched loss keeps coming back while it stays high
    if (los[p] && m_mode[p] == MODE_UNSTRUCTURED)
      m_alarm[p][6] = 1'b1;
    e = s == SLOT_ALARM ? m_alarm[p] : s == SLOT_HIGH ? m_map[p][31:16] : s == SLOT_LOW ? m_map[p][15:0] : '0;
    host.access(w, {BLOCK_PAGE, p[2:0], s}, wd, a, d);
    `CHK("ack", s inside {SLOT_ALARM, SLOT_HIGH, SLOT_LOW}, a)
    if (!w)
      `CHK("rdata", e, d)
    if (w && s == SLOT_CTRL1)
    begin
      m_prog[p] = 1'b1;
      m_mode[p] = wd[14:13];
    end
    if (w && s == SLOT_ALARM)
      m_alarm[p][10:1] = {m_alarm[p][10:6] & (wd[10:6] | {4'h0, !m_prog[p]}), wd[5:1]};
    if (w && s == SLOT_HIGH)
      m_map[p][31:16] &= wd;
    if (w && s == SLOT_LOW)
      m_map[p][15:0] &= wd;
  endtask : rw
  task automatic pulse(input int p, input port_event_type e);
    @(posedge i_clk_sys);
    ev[p] <= e;
    @(posedge i_clk_sys);
    ev[p] <= '0;
    if (m_mode[p] == MODE_UNSTRUCTURED)
      m_alarm[p][7] |= e.udt_outbuf_error;
    if (m_mode[p][1])
    begin
      m_alarm[p][8] |= e.sdt_outbuf_error;
      m_alarm[p][9] |= e.perm_underrun & e.perm_enable;
      m_alarm[p][10] |= e.simple_underrun & e.simple_enable;
      if (e.simple_underrun)
        m_alarm[p][15:11] = e.simple_channel;
      if (e.perm_underrun)
        m_map[p][e.perm_channel] = 1'b1;
    end
  endtask : pulse
  task automatic srv_chk();
    logic [PORT_COUNT-1:0] e;
    repeat (2) @(posedge i_clk_sys);
    #1;
    for (int p = 0; p < PORT_COUNT; p++)
      e[p] = |(m_alarm[p][5:1] & m_alarm[p][10:6]);
    `CHK("port service", e, psrv)
    `CHK("service", |e, srv)
  endtask : srv_chk
  task automatic summarize();
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : summarize
  always @(posedge i_clk_sys)
  begin
    cycles++;
    if (cycles == 30000)
    begin
      bad_count++;
      summarize();
    end
  end
  initial
  begin
    for (int p = 0; p < PORT_COUNT; p++)
    begin
      ev[p] = '0;
      m_alarm[p] = ALARM_RESET;
      m_map[p] = MAP_RESET;
      m_mode[p] = MODE_NONE;
    end
    repeat (12) @(posedge i_clk_sys);
    i_rst <= 1'b0;
    for (int p = 0; p < PORT_COUNT; p++)
    begin
      for (int s = 0; s < 4; s++)
        rw(1'b0, p, 4'(SLOT_ALARM + 2 * s), '0);
      rw(1'b1, p, SLOT_ALARM, 16'h0002);
      rw(1'b1, p, SLOT_CTRL1, {1'b0, 2'(p), 13'h0});
      rw(1'b0, p, SLOT_ALARM, '0);
    end
    srv_chk();
    $display("test reset values and early clear done");
    repeat (200)
    begin
      r = rnd();
      q = r[20:18];
      if (r[17])
        pulse(q, r[15:0]);
      else
        rw(1'b1, q, r[16] ? SLOT_ALARM : (SLOT_HIGH | {2'h0, r[21], 1'h0}), r[15:0]);
      for (int s = 0; s < 3; s++)
        rw(1'b0, q, 4'(SLOT_ALARM + 2 * s), '0);
      srv_chk();
    end
    $display("test random events and clears done");
    for (int k = 0; k < 2; k++)
    begin
      @(posedge i_clk_sys);
      los <= {PORT_COUNT{k == 0}};
      repeat (6) @(posedge i_clk_sys);
      for (int p = 0; p < PORT_COUNT; p++)
      begin
        rw(1'b1, p, SLOT_ALARM, 16'h0002);
        rw(1'b0, p, SLOT_ALARM, '0);
      end
      srv_chk();
    end
    $display("test loss of signal pin done");
    summarize();
  end
endmodule : tdm_port_alarm_status_regs_tb
